// [drum_seq_cfg.svh]
// constants for the drum step sequencer: offsets, fields, reset values, timing
`ifndef DRUM_SEQ_CFG_SVH
`define DRUM_SEQ_CFG_SVH
// register word offsets
`define OFS_TICK 8'h00
`define OFS_TIMER 8'h01
`define OFS_PRESET 8'h02
`define OFS_STEP 8'h03
`define OFS_MODE 8'h04
`define OFS_BASE 8'h05
`define OFS_LAST 8'h06
`define OFS_COLS 8'h07
// table pages, upper address nibble, one word per step
`define PAGE_PAT 4'h1
`define PAGE_CNT 4'h2
`define PAGE_CFG 4'h3
// field positions
`define MODE_RETAIN_BIT 0
`define CFG_TIME_BIT 1
`define CFG_EVENT_BIT 0
`define CFG_SEL_LSB 4
`define CFG_SEL_MSB 7
// reset values
`define PRESET_RST 5'h01
`define LAST_RST 5'h10
`define BASE_RST 16'h0001
`define COLS_RST 16'hFFFF
`define RETAIN_RST 1'b1
`define ZERO16 16'h0000
// step numbering
`define STEP_FIRST 5'h01
`define STEP_MAX 5'h10
// timing
`define CLK_NS 10
`define HUNDREDTH_NS 10000000
`define SCAN_NS 1000000
`endif

// [drum_seq_pkg.sv]
// types shared by the drum step sequencer
package drum_seq_pkg;
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_STEP = 2'b01,
    ST_DONE = 2'b10
  } seqState_t;
  // per-step transition configuration
  typedef struct packed {
    logic [3:0] evSel;
    logic useTime;
    logic useEvent;
  } stepCfg_t;
  // discrete control points from ladder logic
  typedef struct packed {
    logic run;
    logic reset;
    logic start;
    logic jog;
  } ctrlPins_t;
endpackage

// [drum_step_sequencer.sv]
// sixteen-step drum sequencer with timer and event advance and a word register port
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "drum_seq_cfg.svh"
//
// Function
// - per-step event, time or both; partial use
// - four consecutive status words from base
// - done flag sets at finish, clears on reset
// - words: count, timer, preset, current step
// - timer word counts hundredths of a second
// - preset changes only on program write
// - any step final; then flag, complete state
// - complete state holds final step pattern
// - complete state ignores start and jog
// - leave complete on reset or run entry
// - start runs timer and watches events
// - start low freezes all but run entry, reset and jog; outputs held
// - jog rising edge advances one step
// - reset beats start, holds preset step
// - preset one to sixteen, used at run entry
// - each step has optional tick count
// - at most one optional event per step
// - outputs driven whenever in run mode
// - run entry drives current step pattern
// - non-retentive entry zeroes and loads preset
// - counter memory defaults to retentive
// - step time is hundredth times base times count
// - evented step times only while event true
// - jog clears timer; start resumes immediately
module drum_step_sequencer #(
  parameter bit EVENT_VARIANT = 1'b1,
  parameter int unsigned HUNDREDTH_CYCLES = `HUNDREDTH_NS / `CLK_NS,
  parameter int unsigned SCAN_CYCLES = `SCAN_NS / `CLK_NS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData_q,
  input wire drum_seq_pkg::ctrlPins_t ctrlPins,
  input wire logic [15:0] eventPins,
  output logic [15:0] drumOut_q,
  output logic doneFlag_q
);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  drum_seq_pkg::ctrlPins_t ctrlMeta_q;
  drum_seq_pkg::ctrlPins_t ctrlSync_q;
  logic [15:0] evMeta_q;
  logic [15:0] evSync_q;
  logic [31:0] hundCnt_q;
  logic [31:0] scanCnt_q;
  logic hundPend_q;
  logic scanEn_q;
  logic runPrev_q;
  logic jogPrev_q;
  logic [4:0] preset_q;
  logic [4:0] last_q;
  logic [15:0] base_q;
  logic [15:0] colMask_q;
  logic retain_q;
  logic [15:0] pattern_q [16];
  logic [15:0] stepCnt_q [16];
  drum_seq_pkg::stepCfg_t cfgTab_q [16];
  drum_seq_pkg::seqState_t state_q;
  drum_seq_pkg::seqState_t state_d;
  logic [4:0] step_q;
  logic [4:0] step_d;
  logic [15:0] tick_q;
  logic [15:0] tick_d;
  logic [15:0] timer_q;
  logic [15:0] timer_d;
  logic done_d;
  logic advance;
  logic goPreset;
  logic jogRise;
  logic evTrue;
  logic useEv;
  logic [15:0] baseEff;
  logic [15:0] tmrInc;
  logic [15:0] tickInc;
  logic [15:0] rdMux;
  drum_seq_pkg::stepCfg_t curCfg;

  // step number 1..16 to table index 0..15
  function automatic logic [3:0] stepIdx(input logic [4:0] s);
    logic [4:0] t;
    t = s - `STEP_FIRST;
    return t[3:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: control points and events come from outside

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrlMeta_q <= '0;
      ctrlSync_q <= '0;
      evMeta_q <= `ZERO16;
      evSync_q <= `ZERO16;
    end
    else
    begin
      ctrlMeta_q <= ctrlPins;
      ctrlSync_q <= ctrlMeta_q;
      evMeta_q <= eventPins;
      evSync_q <= evMeta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // dividers: scan enable and hundredth-second tick

  // a hundredth tick waits for the next scan; scans slower than
  // a hundredth can merge ticks, as a real scanned controller would
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hundCnt_q <= '0;
      hundPend_q <= 1'b0;
    end
    else
    begin
      if (hundCnt_q == 32'(HUNDREDTH_CYCLES - 1))
      begin
        hundCnt_q <= '0;
        hundPend_q <= 1'b1; // set wins over the scan clear
      end
      else
      begin
        hundCnt_q <= hundCnt_q + 32'h00000001;
        if (scanEn_q)
        begin
          hundPend_q <= 1'b0;
        end
      end
    end
  end

  // one scan enable pulse per scan period
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scanCnt_q <= '0;
      scanEn_q <= 1'b0;
    end
    else
    begin
      scanEn_q <= (scanCnt_q == 32'(SCAN_CYCLES - 1));
      if (scanCnt_q == 32'(SCAN_CYCLES - 1))
      begin
        scanCnt_q <= '0;
      end
      else
      begin
        scanCnt_q <= scanCnt_q + 32'h00000001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers written by the program

  // preset moves only on a program write of a legal step number
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      preset_q <= `PRESET_RST;
      last_q <= `LAST_RST;
      base_q <= `BASE_RST;
      colMask_q <= `COLS_RST;
      retain_q <= `RETAIN_RST;
    end
    else if (regWr)
    begin
      if (regAddr == `OFS_PRESET && regWrData >= 16'(`STEP_FIRST)
          && regWrData <= 16'(`STEP_MAX))
      begin
        preset_q <= regWrData[4:0];
      end
      if (regAddr == `OFS_LAST && regWrData >= 16'(`STEP_FIRST)
          && regWrData <= 16'(`STEP_MAX))
      begin
        last_q <= regWrData[4:0];
      end
      if (regAddr == `OFS_BASE)
      begin
        base_q <= regWrData;
      end
      if (regAddr == `OFS_COLS)
      begin
        colMask_q <= regWrData;
      end
      if (regAddr == `OFS_MODE)
      begin
        retain_q <= regWrData[`MODE_RETAIN_BIT];
      end
    end
  end

  // step tables: pattern, tick count, transition configuration
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 16; i++)
      begin
        pattern_q[i] <= `ZERO16;
        stepCnt_q[i] <= `ZERO16;
        cfgTab_q[i] <= '{evSel: 4'h0, useTime: 1'b1, useEvent: 1'b0};
      end
    end
    else if (regWr)
    begin
      if (regAddr[7:4] == `PAGE_PAT)
      begin
        pattern_q[regAddr[3:0]] <= regWrData;
      end
      if (regAddr[7:4] == `PAGE_CNT)
      begin
        stepCnt_q[regAddr[3:0]] <= regWrData;
      end
      if (regAddr[7:4] == `PAGE_CFG)
      begin
        cfgTab_q[regAddr[3:0]] <= '{
          evSel: regWrData[`CFG_SEL_MSB:`CFG_SEL_LSB],
          useTime: regWrData[`CFG_TIME_BIT],
          useEvent: regWrData[`CFG_EVENT_BIT]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencing

  assign curCfg = cfgTab_q[stepIdx(step_q)];
  assign useEv = EVENT_VARIANT & curCfg.useEvent;
  assign evTrue = evSync_q[curCfg.evSel];
  assign jogRise = EVENT_VARIANT & ctrlSync_q.jog & ~jogPrev_q;
  assign baseEff = (base_q == `ZERO16) ? 16'h0001 : base_q;
  assign tmrInc = timer_q + 16'h0001;
  assign tickInc = tick_q + 16'h0001;

  // next state; only moves on a scan in run mode
  always_comb
  begin
    step_d = step_q;
    tick_d = tick_q;
    timer_d = timer_q;
    done_d = doneFlag_q;
    state_d = state_q;
    advance = 1'b0;
    goPreset = 1'b0;
    if (scanEn_q && ctrlSync_q.run)
    begin
      if (!runPrev_q)
      begin
        goPreset = !retain_q || state_q == drum_seq_pkg::ST_DONE;
      end
      else if (ctrlSync_q.reset)
      begin
        goPreset = 1'b1;
      end
      else if (state_q == drum_seq_pkg::ST_DONE)
      begin
        step_d = step_q;
      end
      else if (jogRise)
      begin
        advance = 1'b1;
      end
      else if (ctrlSync_q.start)
      begin
        if (curCfg.useTime)
        begin
          if (hundPend_q && (!useEv || evTrue))
          begin
            if (tmrInc >= baseEff)
            begin
              timer_d = `ZERO16;
              if (tickInc >= stepCnt_q[stepIdx(step_q)])
              begin
                advance = 1'b1;
              end
              else
              begin
                tick_d = tickInc;
              end
            end
            else
            begin
              timer_d = tmrInc;
            end
          end
        end
        else if (!useEv || evTrue)
        begin
          advance = 1'b1;
        end
      end
      // with start low only run entry, reset or a jog edge moves anything above: frozen otherwise
      if (goPreset)
      begin
        step_d = preset_q;
        tick_d = `ZERO16;
        timer_d = `ZERO16;
        done_d = 1'b0;
        state_d = drum_seq_pkg::ST_STEP;
      end
      if (advance)
      begin
        tick_d = `ZERO16;
        timer_d = `ZERO16;
        if (step_q == last_q)
        begin
          done_d = 1'b1;
          state_d = drum_seq_pkg::ST_DONE;
        end
        else if (step_q == `STEP_MAX)
        begin
          step_d = `STEP_FIRST;
        end
        else
        begin
          step_d = step_q + `STEP_FIRST;
        end
      end
    end
  end

  // step, count, timer, done flag and state; a hardware reset loads them as a fresh start
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      step_q <= `PRESET_RST;
      tick_q <= `ZERO16;
      timer_q <= `ZERO16;
      doneFlag_q <= 1'b0;
      state_q <= drum_seq_pkg::ST_STEP;
    end
    else
    begin
      step_q <= step_d;
      tick_q <= tick_d;
      timer_q <= timer_d;
      doneFlag_q <= done_d;
      state_q <= state_d;
    end
  end

  // edge history, sampled once per scan so edges line up with scans
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      runPrev_q <= 1'b0;
      jogPrev_q <= 1'b0;
    end
    else if (scanEn_q)
    begin
      runPrev_q <= ctrlSync_q.run;
      jogPrev_q <= ctrlSync_q.jog;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // drum outputs

  // built from the next step, so a step change shows in the same cycle;
  // outside run mode the outputs are released to zero
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drumOut_q <= `ZERO16;
    end
    else if (ctrlSync_q.run)
    begin
      drumOut_q <= pattern_q[stepIdx(step_d)] & colMask_q;
    end
    else
    begin
      drumOut_q <= `ZERO16;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read port

  always_comb
  begin
    rdMux = `ZERO16;
    unique case (regAddr[7:4])
      4'h0:
      begin
        case (regAddr)
          `OFS_TICK: rdMux = tick_q;
          `OFS_TIMER: rdMux = timer_q;
          `OFS_PRESET: rdMux = {11'h000, preset_q};
          `OFS_STEP: rdMux = {11'h000, step_q};
          `OFS_MODE: rdMux = {15'h0000, retain_q};
          `OFS_BASE: rdMux = base_q;
          `OFS_LAST: rdMux = {11'h000, last_q};
          `OFS_COLS: rdMux = colMask_q;
          default: rdMux = `ZERO16;
        endcase
      end
      `PAGE_PAT: rdMux = pattern_q[regAddr[3:0]];
      `PAGE_CNT: rdMux = stepCnt_q[regAddr[3:0]];
      `PAGE_CFG: rdMux = {8'h00, cfgTab_q[regAddr[3:0]].evSel, 2'b00,
                          cfgTab_q[regAddr[3:0]].useTime,
                          cfgTab_q[regAddr[3:0]].useEvent};
      default: rdMux = `ZERO16;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdData_q <= `ZERO16;
    end
    else
    begin
      regRdData_q <= regRd ? rdMux : `ZERO16;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  done_clear_a: assert property (
    scanEn_q && ctrlSync_q.run && runPrev_q && ctrlSync_q.reset |=> !doneFlag_q)
    else $error("done flag not cleared by reset");

  reset_preset_a: assert property (
    scanEn_q && ctrlSync_q.run && runPrev_q && ctrlSync_q.reset
    |=> step_q == $past(preset_q) && timer_q == `ZERO16 && tick_q == `ZERO16)
    else $error("reset did not hold preset step");

  out_release_a: assert property (
    !ctrlSync_q.run |=> drumOut_q == `ZERO16)
    else $error("outputs driven outside run mode");

  out_pattern_a: assert property (
    ctrlSync_q.run && !regWr
    |=> drumOut_q == (pattern_q[stepIdx(step_q)] & colMask_q))
    else $error("outputs do not match current step pattern");

  freeze_hold_a: assert property (
    scanEn_q && ctrlSync_q.run && runPrev_q && !ctrlSync_q.reset
    && !ctrlSync_q.start && !jogRise
    |=> $stable(step_q) && $stable(timer_q) && $stable(tick_q))
    else $error("state moved with start low");

  done_ignore_a: assert property (
    scanEn_q && ctrlSync_q.run && runPrev_q && !ctrlSync_q.reset
    && state_q == drum_seq_pkg::ST_DONE
    |=> $stable(step_q) && doneFlag_q && state_q == drum_seq_pkg::ST_DONE)
    else $error("complete state left without reset");

  jog_step_a: assert property (
    scanEn_q && ctrlSync_q.run && runPrev_q && !ctrlSync_q.reset && jogRise
    && state_q == drum_seq_pkg::ST_STEP && step_q < last_q
    |=> step_q == $past(step_q) + `STEP_FIRST && timer_q == `ZERO16)
    else $error("jog did not advance one step");

  preset_write_a: assert property (
    !(regWr && regAddr == `OFS_PRESET) |=> $stable(preset_q))
    else $error("preset changed without a write");

  entry_init_a: assert property (
    scanEn_q && ctrlSync_q.run && !runPrev_q && !retain_q
    |=> tick_q == `ZERO16 && timer_q == `ZERO16 && step_q == $past(preset_q))
    else $error("non-retentive run entry not initialised");

  last_done_a: assert property (
    advance && step_q == last_q |=> doneFlag_q && $stable(step_q))
    else $error("final step did not complete");

endmodule // drum_step_sequencer

// [ladder_io.sv]
// ladder logic partner: drives the drum control points and event points
`timescale 1ns/1ps
module ladder_io (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire drum_seq_pkg::ctrlPins_t ctrlCmd,
  input wire logic [15:0] eventCmd,
  output drum_seq_pkg::ctrlPins_t ctrlPins,
  output logic [15:0] eventPins
);
  ////////////////////////////////////////////////////////////////
  // coils change once per edge, like a scanned program writing its outputs
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrlPins <= '0;
      eventPins <= 16'h0000;
    end
    else
    begin
      ctrlPins <= ctrlCmd;
      eventPins <= eventCmd;
    end
  end
endmodule // ladder_io

// [testbench.sv]
// self-checking bench for the drum step sequencer and its ladder partner
`timescale 1ns/1ps
`include "drum_seq_cfg.svh"
module testbench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData_q;
  drum_seq_pkg::ctrlPins_t ctrlCmd = '0;
  drum_seq_pkg::ctrlPins_t ctrlPins;
  logic [15:0] eventCmd = 16'h0000;
  logic [15:0] eventPins;
  logic [15:0] drumOut_q;
  logic doneFlag_q;
  logic [15:0] pat [1:16];
  logic [15:0] colMask;
  logic [15:0] held [4];
  logic [31:0] seed = 32'h00000043;
  logic [3:0] evIdx;
  logic [15:0] rd;
  logic [7:0] rstAddr [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
  logic [15:0] rstVal [9] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0001,
    16'h0010, 16'hFFFF, 16'h0000};
  int n_fail = 0;
  int num_checks = 0;

  ////////////////////////////////////////////////////////////////
  // clock and instances; short hundredth and scan keep the run brief
  always #5 core_clk = ~core_clk;

  drum_step_sequencer #(.EVENT_VARIANT(1'b1), .HUNDREDTH_CYCLES(40), .SCAN_CYCLES(4)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData_q(regRdData_q), .ctrlPins(ctrlPins),
    .eventPins(eventPins), .drumOut_q(drumOut_q), .doneFlag_q(doneFlag_q));

  ladder_io ladder_u (.core_clk(core_clk), .reset_n(reset_n), .ctrlCmd(ctrlCmd),
    .eventCmd(eventCmd), .ctrlPins(ctrlPins), .eventPins(eventPins));

  ////////////////////////////////////////////////////////////////
  // expectations and random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [15:0] expOut(input int st);
    return pat[st] & colMask;
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus cycles, control changes and comparisons
  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkFlag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: flag got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic regRead(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData_q;
  endtask

  task automatic chkReg(input logic [7:0] a, input logic [15:0] exp);
    regRead(a, rd);
    chkWord(rd, exp);
  endtask

  // wait covers two sync flops plus a full scan plus the update edge
  task automatic drive(input logic r, input logic rs, input logic s, input logic j);
    @(posedge core_clk);
    ctrlCmd <= {r, rs, s, j};
    repeat (12) @(posedge core_clk);
    #1; // step off the edge so registered outputs are read settled
  endtask

  task automatic endTest(input string name);
    $display("test %s finished", name);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      regRead(rstAddr[i], rd);
      chkWord(rd, rstVal[i]);
    end
    endTest("reset values");

    // out of range presets and read-only words must not move
    regWrite(`OFS_PRESET, 16'h0000);
    regWrite(`OFS_PRESET, 16'h0011);
    chkReg(`OFS_PRESET, 16'h0001);
    regWrite(`OFS_TICK, 16'h1234);
    chkReg(`OFS_TICK, 16'h0000);
    regWrite(`OFS_PRESET, 16'h0005);
    chkReg(`OFS_PRESET, 16'h0005);
    regWrite(`OFS_PRESET, 16'h0001);
    endTest("register writes");

    // random patterns and mask, two counts per step, steps one and two longer
    for (int i = 1; i <= 16; i++)
    begin
      seed = xorshift(seed);
      pat[i] = seed[15:0];
      regWrite(8'h10 + 8'(i - 1), pat[i]);
      regWrite(8'h20 + 8'(i - 1), 16'h0002);
    end
    seed = xorshift(seed);
    colMask = seed[31:16];
    regWrite(`OFS_COLS, colMask);
    regWrite(8'h20, 16'h0003);
    regWrite(8'h21, 16'h0064);
    regWrite(`OFS_BASE, 16'h0002);
    chkWord(drumOut_q, 16'h0000);
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    chkWord(drumOut_q, expOut(1));
    endTest("outputs");

    // step one lasts 3 counts of 2 hundredths, 240 clocks
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (168) @(posedge core_clk);
    chkReg(`OFS_STEP, 16'h0001);
    repeat (120) @(posedge core_clk);
    chkReg(`OFS_STEP, 16'h0002);
    chkWord(drumOut_q, expOut(2));
    endTest("step timing");

    // start low freezes count, timer and step
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      regRead(`OFS_TICK + 8'(i), held[i]);
    repeat (200) @(posedge core_clk);
    for (int i = 0; i < 4; i++)
      chkReg(`OFS_TICK + 8'(i), held[i]);
    endTest("freeze");

    // two jog edges with start low
    drive(1'b1, 1'b0, 1'b0, 1'b1);
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b0, 1'b0, 1'b1);
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    chkReg(`OFS_STEP, 16'h0004);
    chkReg(`OFS_TIMER, 16'h0000);
    chkWord(drumOut_q, expOut(4));
    endTest("jog");

    // step four waits on one event point, other points held at random values as noise
    seed = xorshift(seed);
    evIdx = seed[3:0];
    regWrite(8'h33, {8'h00, evIdx, 4'h1});
    eventCmd <= seed[31:16] & ~(16'h0001 << evIdx);
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (100) @(posedge core_clk);
    chkReg(`OFS_STEP, 16'h0004);
    eventCmd <= 16'h0001 << evIdx;
    repeat (12) @(posedge core_clk);
    eventCmd <= 16'h0000;
    chkReg(`OFS_STEP, 16'h0005);
    endTest("event step");

    // step six is the last one
    regWrite(`OFS_LAST, 16'h0006);
    for (int n = 0; n < 2000 && doneFlag_q !== 1'b1; n++)
      @(posedge core_clk);
    chkFlag(doneFlag_q, 1'b1);
    chkReg(`OFS_STEP, 16'h0006);
    chkWord(drumOut_q, expOut(6));
    drive(1'b1, 1'b0, 1'b0, 1'b1);
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    chkReg(`OFS_STEP, 16'h0006);
    chkFlag(doneFlag_q, 1'b1);
    drive(1'b1, 1'b1, 1'b1, 1'b0);
    chkFlag(doneFlag_q, 1'b0);
    chkReg(`OFS_STEP, 16'h0001);
    chkWord(drumOut_q, expOut(1));
    repeat (100) @(posedge core_clk);
    chkReg(`OFS_TIMER, 16'h0000);
    endTest("completion");

    // run entry with plain memory loads the preset
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (300) @(posedge core_clk);
    drive(1'b0, 1'b0, 1'b0, 1'b0);
    chkWord(drumOut_q, 16'h0000);
    regWrite(`OFS_MODE, 16'h0000);
    regWrite(`OFS_PRESET, 16'h0003);
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    chkReg(`OFS_STEP, 16'h0003);
    chkReg(`OFS_TICK, 16'h0000);
    chkReg(`OFS_TIMER, 16'h0000);
    chkReg(`OFS_PRESET, 16'h0003);
    chkWord(drumOut_q, expOut(3));
    // retentive memory keeps the step across a run cycle
    regWrite(`OFS_MODE, 16'h0001);
    drive(1'b1, 1'b0, 1'b0, 1'b1);
    drive(1'b0, 1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    chkReg(`OFS_STEP, 16'h0004);
    chkWord(drumOut_q, expOut(4));
    endTest("run entry");

    // timed step four now also needs its event point; time counts only while it is high
    regWrite(8'h33, {8'h00, evIdx, 4'h3});
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (200) @(posedge core_clk);
    chkReg(`OFS_TIMER, 16'h0000);
    chkReg(`OFS_STEP, 16'h0004);
    eventCmd <= 16'h0001 << evIdx;
    repeat (200) @(posedge core_clk);
    eventCmd <= 16'h0000;
    chkReg(`OFS_STEP, 16'h0005);
    endTest("event timer");
    final_report();
  end
endmodule // testbench
